//--- pkg/plr_pkg.sv
// constants and helpers for the pin-level read register bank
`default_nettype none

package plr_pkg;

   // number of pin groups that own a register
   localparam int GROUPS = 13;

   // apb data and address widths
   localparam int DATA_W = 32;
   localparam int ADDR_W = 32;
   localparam int LEVEL_W = 8;

   // register word indexes; the byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_GROUP1 = 32'h0008C041;
   localparam logic [ADDR_W-1:0] IDX_GROUP2 = 32'h0008C042;
   localparam logic [ADDR_W-1:0] IDX_GROUP3 = 32'h0008C043;
   localparam logic [ADDR_W-1:0] IDX_GROUP4 = 32'h0008C044;
   localparam logic [ADDR_W-1:0] IDX_GROUP5 = 32'h0008C045;
   localparam logic [ADDR_W-1:0] IDX_GROUP6 = 32'h0008C046;
   localparam logic [ADDR_W-1:0] IDX_GROUP7 = 32'h0008C047;
   localparam logic [ADDR_W-1:0] IDX_GROUP8 = 32'h0008C048;
   localparam logic [ADDR_W-1:0] IDX_GROUP9 = 32'h0008C049;
   localparam logic [ADDR_W-1:0] IDX_GROUP_A = 32'h0008C04A;
   localparam logic [ADDR_W-1:0] IDX_GROUP_B = 32'h0008C04B;
   localparam logic [ADDR_W-1:0] IDX_GROUP_D = 32'h0008C04D;
   localparam logic [ADDR_W-1:0] IDX_GROUP_E = 32'h0008C04E;
   // control register: freeze of the sampled levels
   localparam logic [ADDR_W-1:0] IDX_CTRL = 32'h0008C050;

   // word index to byte address shift
   localparam int IDX_SHIFT = 2;

   // implemented low-order bits per group
   localparam int IMPL_GROUP1 = 2;
   localparam int IMPL_GROUP2 = 5;
   localparam int IMPL_GROUP3 = 4;
   localparam int IMPL_GROUP4 = 8;
   localparam int IMPL_GROUP5 = 6;
   localparam int IMPL_GROUP6 = 6;
   localparam int IMPL_GROUP7 = 7;
   localparam int IMPL_GROUP8 = 3;
   localparam int IMPL_GROUP9 = 7;
   localparam int IMPL_GROUP_A = 6;
   localparam int IMPL_GROUP_B = 8;
   localparam int IMPL_GROUP_D = 8;
   localparam int IMPL_GROUP_E = 6;

   // control register layout and reset
   localparam int CTRL_FREEZE_BIT = 0;
   localparam logic CTRL_FREEZE_RESET = 1'b0;

   // decoder slot codes beyond the group slots
   localparam logic [4:0] SLOT_CTRL = 5'h0D;
   localparam logic [4:0] SLOT_NONE = 5'h1F;

   // constant read and reset values
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;
   localparam logic [LEVEL_W-1:0] LEVEL_ONES = 8'hFF;

   // apb phase tracking
   typedef enum logic [1:0] {
      PLR_IDLE = 2'b00,
      PLR_WAIT = 2'b01,
      PLR_DONE = 2'b10
   } plr_phase_t;

endpackage

`default_nettype wire

//--- src/plr_sync.sv
// two-stage synchroniser for a bundle of pin levels
`timescale 1ns/10ps
`default_nettype none

module plr_sync #(
   parameter int WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;

   // no reset: the sampled value must follow the pins, not a constant
   always_ff @(posedge clk_i) begin
      stage1 <= async_i;
      stage2 <= stage1;
   end

   // only the second stage leaves the module
   assign sync_o = stage2;

endmodule

`default_nettype wire

//--- src/plr_bank.sv
// pin-level read register bank behind an apb slave
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Each implemented bit of a pin-level register reads the present level of pin n of its group at bit n;
//   while the freeze bit is set the code returns the last sampled level instead.
// - Every unimplemented bit position in the low byte of a pin-level register reads as one; bits 31 to 8 read as zero.
// - Writes to a pin-level register change nothing, implemented or unimplemented bits alike.
// - Group 1 implements two low bits, group 2 five and group 3 four.
// - Groups 5, 6, A and E implement their lowest six bits only.
// - Groups 7 and 9 implement their lowest seven bits, the top bit being unimplemented.
// - Group 8 implements its lowest three bits only.
// - After reset a pin-level register holds no fixed constant but whatever the pins carry.
// - The registers sit at consecutive indexes, the group selecting the low nibble, with no register for C and F.
module plr_bank (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [plr_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [plr_pkg::DATA_W-1:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [plr_pkg::DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [plr_pkg::LEVEL_W-1:0] pin_group1_i,
   input wire logic [plr_pkg::LEVEL_W-1:0] pin_group2_i,
   input wire logic [plr_pkg::LEVEL_W-1:0] pin_group3_i,
   input wire logic [plr_pkg::LEVEL_W-1:0] pin_group4_i,
   input wire logic [plr_pkg::LEVEL_W-1:0] pin_group5_i,
   input wire logic [plr_pkg::LEVEL_W-1:0] pin_group6_i,
   input wire logic [plr_pkg::LEVEL_W-1:0] pin_group7_i,
   input wire logic [plr_pkg::LEVEL_W-1:0] pin_group8_i,
   input wire logic [plr_pkg::LEVEL_W-1:0] pin_group9_i,
   input wire logic [plr_pkg::LEVEL_W-1:0] pin_group_a_i,
   input wire logic [plr_pkg::LEVEL_W-1:0] pin_group_b_i,
   input wire logic [plr_pkg::LEVEL_W-1:0] pin_group_d_i,
   input wire logic [plr_pkg::LEVEL_W-1:0] pin_group_e_i
);

   localparam int G = plr_pkg::GROUPS;
   localparam int LW = plr_pkg::LEVEL_W;

   // word indexes in slot order
   localparam logic [plr_pkg::ADDR_W-1:0] SLOT_INDEX [G] = '{
      plr_pkg::IDX_GROUP1, plr_pkg::IDX_GROUP2, plr_pkg::IDX_GROUP3,
      plr_pkg::IDX_GROUP4, plr_pkg::IDX_GROUP5, plr_pkg::IDX_GROUP6,
      plr_pkg::IDX_GROUP7, plr_pkg::IDX_GROUP8, plr_pkg::IDX_GROUP9,
      plr_pkg::IDX_GROUP_A, plr_pkg::IDX_GROUP_B, plr_pkg::IDX_GROUP_D,
      plr_pkg::IDX_GROUP_E
   };

   // implemented width per slot
   localparam int SLOT_IMPL [G] = '{
      plr_pkg::IMPL_GROUP1, plr_pkg::IMPL_GROUP2, plr_pkg::IMPL_GROUP3,
      plr_pkg::IMPL_GROUP4, plr_pkg::IMPL_GROUP5, plr_pkg::IMPL_GROUP6,
      plr_pkg::IMPL_GROUP7, plr_pkg::IMPL_GROUP8, plr_pkg::IMPL_GROUP9,
      plr_pkg::IMPL_GROUP_A, plr_pkg::IMPL_GROUP_B, plr_pkg::IMPL_GROUP_D,
      plr_pkg::IMPL_GROUP_E
   };

   // byte address of a word index
   function automatic logic [plr_pkg::ADDR_W-1:0] byte_addr(input logic [plr_pkg::ADDR_W-1:0] idx);
      byte_addr = idx << plr_pkg::IDX_SHIFT;
   endfunction

   // mask with ones on the implemented low bits
   function automatic logic [LW-1:0] impl_mask(input int impl);
      logic [LW-1:0] m;
      m = '0;
      for (int b = 0; b < LW; b++) begin
         if (b < impl) begin
            m[b] = 1'b1;
         end
      end
      impl_mask = m;
   endfunction

   // map a bus address to a slot, or to none
   function automatic logic [4:0] decode(input logic [plr_pkg::ADDR_W-1:0] addr);
      logic [4:0] s;
      s = plr_pkg::SLOT_NONE;
      for (int k = 0; k < G; k++) begin
         if (addr == byte_addr(SLOT_INDEX[k])) begin
            s = 5'(k);
         end
      end
      if (addr == byte_addr(plr_pkg::IDX_CTRL)) begin
         s = plr_pkg::SLOT_CTRL;
      end
      decode = s;
   endfunction

   // raw pin bundles in slot order
   logic [LW-1:0] pin_raw [G];
   logic [LW-1:0] pin_sync [G];
   logic [LW-1:0] pin_level [G];

   assign pin_raw[0] = pin_group1_i;
   assign pin_raw[1] = pin_group2_i;
   assign pin_raw[2] = pin_group3_i;
   assign pin_raw[3] = pin_group4_i;
   assign pin_raw[4] = pin_group5_i;
   assign pin_raw[5] = pin_group6_i;
   assign pin_raw[6] = pin_group7_i;
   assign pin_raw[7] = pin_group8_i;
   assign pin_raw[8] = pin_group9_i;
   assign pin_raw[9] = pin_group_a_i;
   assign pin_raw[10] = pin_group_b_i;
   assign pin_raw[11] = pin_group_d_i;
   assign pin_raw[12] = pin_group_e_i;

   // control: freeze holds the last sampled levels
   logic freeze;

   // one synchroniser per group, then an optional hold stage
   for (genvar g = 0; g < G; g++) begin : g_grp
      plr_sync #(
         .WIDTH(LW)
      ) u_sync (
         .clk_i(clk_i),
         .async_i(pin_raw[g]),
         .sync_o(pin_sync[g])
      );

      // no reset value, levels track the pins
      always_ff @(posedge clk_i) begin
         if (!freeze) begin
            pin_level[g] <= pin_sync[g];
         end
      end
   end

   // read view: implemented bits live, others forced high
   logic [LW-1:0] read_view [G];

   always_comb begin
      for (int k = 0; k < G; k++) begin
         read_view[k] = (pin_level[k] & impl_mask(SLOT_IMPL[k])) | ~impl_mask(SLOT_IMPL[k]);
      end
   end

   // apb decode of the current request
   logic [4:0] slot;
   logic misaligned;
   logic access;
   logic hit;
   plr_pkg::plr_phase_t phase;

   // consecutive indexes, c and f left unmapped
   assign slot = decode(paddr_i);
   assign misaligned = (paddr_i[1:0] != 2'b00);
   assign hit = (slot != plr_pkg::SLOT_NONE) && !misaligned;
   assign access = psel_i && penable_i;

   // read data for the decoded slot, zero above the low byte
   logic [plr_pkg::DATA_W-1:0] next_prdata;

   always_comb begin
      next_prdata = plr_pkg::DATA_ZERO;
      if (hit && slot == plr_pkg::SLOT_CTRL) begin
         next_prdata[plr_pkg::CTRL_FREEZE_BIT] = freeze;
      end else if (hit) begin
         next_prdata[LW-1:0] = read_view[slot[3:0]];
      end
   end

   // phase tracker: one wait state, then pready for one cycle
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase <= plr_pkg::PLR_IDLE;
      end else begin
         unique case (phase)
            plr_pkg::PLR_IDLE: begin
               if (access) begin
                  phase <= plr_pkg::PLR_DONE;
               end
            end
            plr_pkg::PLR_DONE: begin
               phase <= plr_pkg::PLR_IDLE;
            end
            default: begin
               phase <= plr_pkg::PLR_IDLE;
            end
         endcase
      end
   end

   // answer registers: pready follows the phase
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pready_o <= 1'b0;
      end else begin
         pready_o <= (phase == plr_pkg::PLR_IDLE) && access;
      end
   end

   // read data captured as pready rises, cleared otherwise
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prdata_o <= plr_pkg::DATA_ZERO;
      end else if ((phase == plr_pkg::PLR_IDLE) && access && !pwrite_i) begin
         prdata_o <= next_prdata;
      end else begin
         prdata_o <= plr_pkg::DATA_ZERO;
      end
   end

   // error for unmapped or misaligned words; level writes are quiet
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pslverr_o <= 1'b0;
      end else begin
         pslverr_o <= (phase == plr_pkg::PLR_IDLE) && access && !hit;
      end
   end

   // control write takes effect at the completing edge only
   // level slots take no write path at all
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         freeze <= plr_pkg::CTRL_FREEZE_RESET;
      end else if (access && pready_o && pwrite_i && hit && slot == plr_pkg::SLOT_CTRL && pstrb_i[0]) begin
         freeze <= pwdata_i[plr_pkg::CTRL_FREEZE_BIT];
      end
   end

endmodule

`default_nettype wire

//--- tb/plr_bank_props.sv
// assertion checker for the pin-level read bank
`timescale 1ns/10ps
`default_nettype none
module plr_bank_props (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [plr_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [plr_pkg::DATA_W-1:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // byte address of a group nibble
   function automatic logic [31:0] ba(input logic [3:0] nib);
      return {28'h0008C04, nib} << 2;
   endfunction
   // fresh access phase, before the slave answers
   sequence acc_at(logic [31:0] a);
      psel_i && penable_i && !pready_o && paddr_i == a;
   endsequence
   sequence rd_at(logic [31:0] a);
      acc_at(a) ##0 !pwrite_i;
   endsequence
   ready_answer_a:
      assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("no ready after access");
   ready_pulse_a:
      assert property (pready_o |=> !pready_o) else $error("ready longer than one cycle");
   idle_data_a:
      assert property (!pready_o |-> prdata_o == '0) else $error("read data outside ready");
   err_ready_a:
      assert property (pslverr_o |-> pready_o) else $error("error without ready");
   upper_zero_a:
      assert property (pready_o |-> prdata_o[31:8] == '0) else $error("upper read bits set");
   group1_fill_a:
      assert property (rd_at(ba(4'h1)) |=> prdata_o[7:2] == 6'h3F) else $error("group 1 fill wrong");
   group5_fill_a:
      assert property (rd_at(ba(4'h5)) |=> prdata_o[7:6] == 2'h3) else $error("group 5 fill wrong");
   group7_fill_a:
      assert property (rd_at(ba(4'h7)) |=> prdata_o[7]) else $error("group 7 fill wrong");
   group8_fill_a:
      assert property (rd_at(ba(4'h8)) |=> prdata_o[7:3] == 5'h1F) else $error("group 8 fill wrong");
   hole_error_a:
      assert property (acc_at(ba(4'hC)) or acc_at(ba(4'hF)) |=> pslverr_o && prdata_o == '0)
         else $error("hole not refused");
   level_write_a:
      assert property (acc_at(ba(4'h4)) ##0 pwrite_i |=> pready_o && !pslverr_o) else $error("level write refused");
endmodule
bind plr_bank plr_bank_props plr_bank_props_inst (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o));
`default_nettype wire

//--- tb/plr_pins.sv
// behavioural model of the external pins of every group
`timescale 1ns/10ps
`default_nettype none
module plr_pins (
   input wire logic [7:0] lvl_i [plr_pkg::GROUPS],
   output logic [7:0] pin_o [plr_pkg::GROUPS]
);
   // pins driven hard; the delay keeps edges off the clock, as real pins are asynchronous
   assign #1 pin_o = lvl_i;
endmodule
`default_nettype wire

//--- tb/plr_bank_tb_top.sv
// self-checking bench for the pin-level read bank
`timescale 1ns/10ps
`default_nettype none
module plr_bank_tb_top;
   typedef struct {logic [3:0] nib; int impl;} plr_row_t;
   logic clk_i, rstn_i, psel, penable, pwrite, err;
   logic [31:0] paddr, pwdata, prdata_o, rd;
   logic pready_o, pslverr_o;
   logic [7:0] lvl [13];
   logic [7:0] pin [13];
   logic [7:0] pats [4] = '{8'h00, 8'hFF, 8'hA5, 8'h5A};
   // address nibble beside implemented width, which sets the expected fill
   plr_row_t rows [13] = '{'{4'h1, 2}, '{4'h2, 5}, '{4'h3, 4}, '{4'h4, 8}, '{4'h5, 6}, '{4'h6, 6}, '{4'h7, 7},
      '{4'h8, 3}, '{4'h9, 7}, '{4'hA, 6}, '{4'hB, 8}, '{4'hD, 8}, '{4'hE, 6}};
   int num_errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   plr_bank plr_bank_inst (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .pin_group1_i(pin[0]), .pin_group2_i(pin[1]), .pin_group3_i(pin[2]),
      .pin_group4_i(pin[3]), .pin_group5_i(pin[4]), .pin_group6_i(pin[5]), .pin_group7_i(pin[6]),
      .pin_group8_i(pin[7]), .pin_group9_i(pin[8]), .pin_group_a_i(pin[9]), .pin_group_b_i(pin[10]),
      .pin_group_d_i(pin[11]), .pin_group_e_i(pin[12]));
   plr_pins plr_pins_inst (.lvl_i(lvl), .pin_o(pin));
   function automatic logic [31:0] ba(input logic [3:0] nib);
      return {28'h0008C04, nib} << 2;
   endfunction
   task automatic print_verdict();
      $display("checked %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      chk_data({31'h0, got}, {31'h0, exp});
   endtask
   // one apb transfer; request held until ready is sampled high
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] d,
      output logic e);
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_i);
      penable <= 1'b1;
      // no limit of its own: the cycle guard ends a hung wait with a fail
      do begin
         @(posedge clk_i);
      end while (pready_o !== 1'b1);
      d = prdata_o;
      e = pslverr_o;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // hang guard, far beyond the few hundred cycles needed
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors++;
         print_verdict();
      end
   end
   initial begin
      rstn_i = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      foreach (lvl[g]) lvl[g] = 8'h00;
      repeat (8) @(posedge clk_i);
      rstn_i <= 1'b1;
      // every group under several pin patterns
      foreach (pats[p]) begin
         @(posedge clk_i);
         foreach (lvl[g]) lvl[g] <= pats[p] + 8'(g);
         repeat (4) @(posedge clk_i);
         foreach (rows[g]) begin
            apb(1'b0, ba(rows[g].nib), '0, rd, err);
            chk_data(rd, {24'h0, lvl[g] | (8'hFF << rows[g].impl)});
            chk_flag(err, 1'b0);
         end
      end
      // writes leave read values untouched
      apb(1'b1, ba(4'h1), 32'h0, rd, err);
      apb(1'b1, ba(4'h4), {24'h0, ~lvl[3]}, rd, err);
      chk_flag(err, 1'b0);
      apb(1'b0, ba(4'h1), '0, rd, err);
      chk_data(rd, {24'h0, lvl[0] | 8'hFC});
      apb(1'b0, ba(4'h4), '0, rd, err);
      chk_data(rd, {24'h0, lvl[3]});
      // freeze holds the old sample until it is cleared again
      apb(1'b1, 32'h00230140, 32'h1, rd, err);
      apb(1'b0, 32'h00230140, '0, rd, err);
      chk_data(rd, 32'h1);
      lvl[3] <= ~lvl[3];
      repeat (4) @(posedge clk_i);
      apb(1'b0, ba(4'h4), '0, rd, err);
      chk_data(rd, {24'h0, ~lvl[3]});
      apb(1'b1, 32'h00230140, 32'h0, rd, err);
      repeat (4) @(posedge clk_i);
      apb(1'b0, ba(4'h4), '0, rd, err);
      chk_data(rd, {24'h0, lvl[3]});
      // holes and a misaligned address are refused
      apb(1'b0, ba(4'hC), '0, rd, err);
      chk_flag(err, 1'b1);
      apb(1'b0, ba(4'hF), '0, rd, err);
      chk_data(rd, '0);
      chk_flag(err, 1'b1);
      apb(1'b0, ba(4'h1) + 32'h1, '0, rd, err);
      chk_flag(err, 1'b1);
      // reset mid-run while a pin moves
      @(posedge clk_i);
      rstn_i <= 1'b0;
      lvl[11] <= 8'h96;
      repeat (3) @(posedge clk_i);
      chk_flag(pready_o, 1'b0);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      apb(1'b0, ba(4'hD), '0, rd, err);
      chk_data(rd, 32'h00000096);
      print_verdict();
   end
endmodule
`default_nettype wire
